// ---- logic/itp_target.sv ----
// I2C target with register space, interrupt pin generator and APB port
//
// Summary of operation
// - Each byte is followed by a ninth acknowledge clock made by the master.
// - The sender frees SDA in the ack slot; the receiver holds it low.
// - The first byte after START is a 7-bit address and a direction bit.
// - An undefined register address gets a NACK and the target goes idle.
// - Multi-byte writes and reads cover consecutive registers.
// - Adapter, over-temperature and charge-done edges both pulse INT 1 ms.
// - Load-insert bits pulse INT 1 ms on a rising edge only.
// - The bus-rail short bit holds INT asserted while it is high.
// - Load-insert bits latch and clear on host read; others are live.
// - A set mask bit keeps a source off INT but its status still updates.
// - The target answers only to address 0x74 and ignores others.
// - Bytes are eight bits MSB first; the target never stretches SCL.
module itp_target #(
   parameter int PULSE_CYCLES = itp_pkg::PULSE_CYCLES,
   parameter bit INT_ACTIVE_LOW = 1'b1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             arst_n,
   // APB slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   output logic                  irq,
   // I2C pins, open drain
   input  wire logic             scl_i,
   output logic                  scl_o,
   output logic                  scl_oe,
   input  wire logic             sda_i,
   output logic                  sda_o,
   output logic                  sda_oe,
   // Status sources and interrupt pin
   input  wire itp_pkg::itp_stat_t status_i,
   output logic                  int_o,
   output logic                  int_oe
);
   import itp_pkg::*;

   function automatic logic [31:0] pulse_next(input logic [31:0] cur,
                                              input logic fire);
      logic [31:0] r;
      r = 32'h0;
      if (fire)
         r = 32'(PULSE_CYCLES);
      else if (cur != 32'h0)
         r = cur - 32'h1;
      return r;
   endfunction

   // Two-flop synchronisers for pins and status sources
   logic [9:0] sync1;
   logic [9:0] sync2;
   logic       scl_q;
   logic       sda_q;
   logic [7:0] stat_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         // Status bits idle low, so no false edge after reset
         sync1  <= 10'h300;
         sync2  <= 10'h300;
         scl_q  <= 1'b1;
         sda_q  <= 1'b1;
         stat_q <= 8'h00;
      end else begin
         sync1  <= {scl_i, sda_i, status_i};
         sync2  <= sync1;
         scl_q  <= sync2[9];
         sda_q  <= sync2[8];
         stat_q <= sync2[7:0];
      end
   end

   logic       scl_s;
   logic       sda_s;
   logic [7:0] stat_s;
   logic       scl_rise;
   logic       scl_fall;
   logic       start;
   logic       stop;
   assign scl_s    = sync2[9];
   assign sda_s    = sync2[8];
   assign stat_s   = sync2[7:0] & ~8'h81;
   assign scl_rise = scl_s & ~scl_q;
   assign scl_fall = ~scl_s & scl_q;
   assign start    = scl_s & scl_q & sda_q & ~sda_s;
   assign stop     = scl_s & scl_q & ~sda_q & sda_s;

   // Interrupt sources
   logic [7:0] rise;
   logic [7:0] fall;
   logic [7:0] ev;
   logic [7:0] ev_m;
   assign rise = stat_s & ~(stat_q & ~8'h81);
   assign fall = ~stat_s & (stat_q & ~8'h81);
   assign ev   = ((rise | fall) & EDGE_BOTH) | (rise & RISE_ONLY);

   // Bus state
   itp_state_t state, next_state;
   logic [3:0]  cnt, next_cnt;
   logic [7:0]  sh, next_sh;
   logic [7:0]  ptr, next_ptr;
   logic        rw, next_rw;
   logic        next_sda_oe;
   logic [7:0]  regs [USER_REGS];
   logic [7:0]  next_regs [USER_REGS];
   logic [7:0]  mask, next_mask;
   logic [7:0]  latch, next_latch;
   logic [31:0] pulse, next_pulse;
   logic        next_int_act;
   // APB state
   logic [31:0] ctrl, next_ctrl;
   logic [2:0]  irq_st, next_irq_st;
   logic [2:0]  irq_msk, next_irq_msk;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic        next_irq;
   // Events and helpers
   logic        stat_rd;
   logic        do_load;
   logic        ev_write;
   logic        ev_nack;
   logic        ev_stop;
   logic [7:0]  stat_view;
   logic [7:0]  rd_val;
   logic        acc;

   assign ev_m = ev & ~mask;

   assign stat_view = (stat_s & ~LATCH_SRC) | latch;

   always_comb begin
      rd_val = UNMAPPED_BYTE;
      if (ptr == STATUS_IDX)
         rd_val = stat_view;
      else if (ptr == MASK_IDX)
         rd_val = mask;
      else if (ptr < 8'(USER_REGS))
         rd_val = regs[ptr[2:0]];
   end

   always_comb begin
      next_state  = state;
      next_cnt    = cnt;
      next_sh     = sh;
      next_ptr    = ptr;
      next_rw     = rw;
      next_sda_oe = sda_oe;
      next_regs   = regs;
      next_mask   = mask;
      stat_rd     = 1'b0;
      do_load     = 1'b0;
      ev_write    = 1'b0;
      ev_nack     = 1'b0;
      ev_stop     = 1'b0;
      if (!ctrl[0]) begin
         next_state  = S_IDLE;
         next_sda_oe = 1'b0;
      end else if (start) begin
         next_state  = S_ADDR;
         next_cnt    = 4'h0;
         next_sda_oe = 1'b0;
      end else if (stop) begin
         ev_stop     = (state != S_IDLE);
         next_state  = S_IDLE;
         next_sda_oe = 1'b0;
      end else begin
         case (state)
            S_ADDR, S_REG, S_WDATA: begin
               if (scl_rise) begin
                  next_sh  = {sh[6:0], sda_s};
                  next_cnt = 4'(cnt + 4'h1);
               end else if (scl_fall && cnt == 4'h8) begin
                  next_cnt = 4'h0;
                  if (state == S_ADDR) begin
                     if (sh[7:1] == TARGET_ADDR) begin
                        next_rw     = sh[0];
                        next_sda_oe = 1'b1;
                        next_state  = S_AACK;
                     end else begin
                        next_state = S_IDLE;
                     end
                  end else if (state == S_REG) begin
                     if (sh <= LAST_IDX) begin
                        next_ptr    = sh;
                        next_sda_oe = 1'b1;
                        next_state  = S_PACK;
                     end else begin
                        ev_nack    = 1'b1;
                        next_state = S_IDLE;
                     end
                  end else if (ptr <= LAST_IDX) begin
                     if (ptr == MASK_IDX)
                        next_mask = sh;
                     else if (ptr < 8'(USER_REGS))
                        next_regs[ptr[2:0]] = sh;
                     next_ptr    = 8'(ptr + 8'h1);
                     ev_write    = 1'b1;
                     next_sda_oe = 1'b1;
                     next_state  = S_DACK;
                  end else begin
                     ev_nack    = 1'b1;
                     next_state = S_IDLE;
                  end
               end
            end
            S_AACK, S_PACK, S_DACK: begin
               if (scl_fall) begin
                  next_sda_oe = 1'b0;
                  if (state == S_AACK && rw)
                     do_load = 1'b1;
                  else if (state == S_AACK)
                     next_state = S_REG;
                  else
                     next_state = S_WDATA;
               end
            end
            S_RDATA: begin
               if (scl_fall) begin
                  if (cnt == 4'h8) begin
                     next_sda_oe = 1'b0;
                     next_cnt    = 4'h0;
                     next_state  = S_MACK;
                  end else begin
                     next_sh     = {sh[6:0], 1'b0};
                     next_sda_oe = ~sh[6];
                     next_cnt    = 4'(cnt + 4'h1);
                  end
               end
            end
            S_MACK: begin
               if (scl_rise)
                  next_cnt = {3'h0, sda_s};
               else if (scl_fall) begin
                  if (cnt[0])
                     next_state = S_IDLE;
                  else
                     do_load = 1'b1;
               end
            end
            default: next_state = S_IDLE;
         endcase
      end
      if (do_load) begin
         next_sh     = rd_val;
         next_sda_oe = ~rd_val[7];
         next_cnt    = 4'h1;
         next_ptr    = 8'(ptr + 8'h1);
         stat_rd     = (ptr == STATUS_IDX);
         next_state  = S_RDATA;
      end
   end

   // Interrupt pin logic; a new edge wins over a read clear
   always_comb begin
      next_latch = stat_rd ? (rise & LATCH_SRC)
                           : (latch | (rise & LATCH_SRC));
      next_pulse = pulse_next(pulse, |ev_m);
      next_int_act = (next_pulse != 32'h0) ||
                     ((stat_s & LEVEL_SRC & ~mask) != 8'h00);
   end

   // APB slave, one wait state per access
   always_comb begin
      acc          = psel & penable & pready;
      next_pready  = psel & penable & ~pready;
      next_prdata  = prdata;
      next_pslverr = 1'b0;
      next_ctrl    = ctrl;
      next_irq_msk = irq_msk;
      next_irq_st  = irq_st;
      if (acc && pwrite) begin
         if (paddr == A_CTRL)
            next_ctrl = {31'h0, pwdata[0]};
         else if (paddr == A_IRQ_MASK)
            next_irq_msk = pwdata[2:0];
         else if (paddr == A_IRQ_STAT)
            next_irq_st = irq_st & ~pwdata[2:0];
      end
      next_irq_st[IRQ_WRITE] = next_irq_st[IRQ_WRITE] | ev_write;
      next_irq_st[IRQ_NACK]  = next_irq_st[IRQ_NACK] | ev_nack;
      next_irq_st[IRQ_STOP]  = next_irq_st[IRQ_STOP] | ev_stop;
      if (next_pready) begin
         next_pslverr = 1'b0;
         case (paddr)
            A_CTRL:     next_prdata = ctrl;
            A_IRQ_STAT: next_prdata = {29'h0, irq_st};
            A_IRQ_MASK: next_prdata = {29'h0, irq_msk};
            A_LIVE:     next_prdata = {20'h0, 4'(state), ptr};
            default: begin
               next_prdata  = 32'h0;
               next_pslverr = 1'b1;
            end
         endcase
      end
      next_irq = (next_irq_st & next_irq_msk) != 3'h0;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state   <= S_IDLE;
         cnt     <= 4'h0;
         sh      <= 8'h00;
         ptr     <= 8'h00;
         rw      <= 1'b0;
         sda_oe  <= 1'b0;
         sda_o   <= 1'b0;
         scl_o   <= 1'b0;
         scl_oe  <= 1'b0;
         for (int i = 0; i < USER_REGS; i++)
            regs[i] <= USER_RESET;
         mask    <= MASK_RESET;
         latch   <= 8'h00;
         pulse   <= 32'h0;
         int_o   <= 1'b0;
         int_oe  <= 1'b0;
         ctrl    <= CTRL_RESET;
         irq_st  <= 3'h0;
         irq_msk <= IRQ_M_RESET;
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         irq     <= 1'b0;
      end else begin
         state   <= next_state;
         cnt     <= next_cnt;
         sh      <= next_sh;
         ptr     <= next_ptr;
         rw      <= next_rw;
         sda_oe  <= next_sda_oe;
         sda_o   <= 1'b0;
         // stretching never needed at this clock rate
         scl_o   <= 1'b0;
         scl_oe  <= 1'b0;
         regs    <= next_regs;
         mask    <= next_mask;
         latch   <= next_latch;
         pulse   <= next_pulse;
         int_o   <= ~INT_ACTIVE_LOW;
         int_oe  <= next_int_act;
         ctrl    <= next_ctrl;
         irq_st  <= next_irq_st;
         irq_msk <= next_irq_msk;
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
         irq     <= next_irq;
      end
   end

   property p_addr_ack;
      @(posedge clk) disable iff (!arst_n)
      (state == S_AACK && scl_rise && !start && !stop) |-> sda_oe;
   endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("address ack not driven");

   property p_nack_idle;
      @(posedge clk) disable iff (!arst_n)
      (ctrl[0] && !start && !stop && state == S_REG && scl_fall &&
       cnt == 4'h8 && sh > LAST_IDX) |=> (state == S_IDLE && !sda_oe);
   endproperty
   a_nack_idle: assert property (p_nack_idle)
      else $error("bad register address not refused");

   property p_foreign;
      @(posedge clk) disable iff (!arst_n)
      (ctrl[0] && !start && !stop && state == S_ADDR && scl_fall &&
       cnt == 4'h8 && sh[7:1] != TARGET_ADDR) |=> (state == S_IDLE);
   endproperty
   a_foreign: assert property (p_foreign)
      else $error("foreign address answered");

   property p_read_dir;
      @(posedge clk) disable iff (!arst_n)
      (ctrl[0] && !start && !stop && state == S_AACK && scl_fall && rw)
      |=> (state == S_RDATA && cnt == 4'h1);
   endproperty
   a_read_dir: assert property (p_read_dir)
      else $error("read direction not served");

   property p_step;
      @(posedge clk) disable iff (!arst_n)
      ev_write |=> (ptr == 8'($past(ptr) + 8'h1)) && (state == S_DACK);
   endproperty
   a_step: assert property (p_step)
      else $error("pointer did not step after write");

   property p_pulse;
      @(posedge clk) disable iff (!arst_n)
      (ev_m[6] || ev_m[2] || ev_m[1]) |=>
      (pulse == 32'(PULSE_CYCLES)) ##1 int_oe;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("edge did not start pulse");

   property p_no_fall;
      @(posedge clk) disable iff (!arst_n)
      ((fall & RISE_ONLY) != 8'h00 && (rise & RISE_ONLY) == 8'h00 &&
       (ev_m & ~RISE_ONLY) == 8'h00 && pulse == 32'h0) |=> pulse == 32'h0;
   endproperty
   a_no_fall: assert property (p_no_fall)
      else $error("falling insert edge raised event");

   property p_short;
      @(posedge clk) disable iff (!arst_n)
      (stat_s[3] && !mask[3]) [*2] |-> int_oe;
   endproperty
   a_short: assert property (p_short)
      else $error("short did not hold pin");

   property p_rd_clear;
      @(posedge clk) disable iff (!arst_n)
      (stat_rd && (rise & LATCH_SRC) == 8'h00) |=> latch == 8'h00;
   endproperty
   a_rd_clear: assert property (p_rd_clear)
      else $error("insert latch not cleared on read");

   property p_mask;
      @(posedge clk) disable iff (!arst_n)
      (mask[3] && pulse == 32'h0 && (ev & ~mask) == 8'h00) |=> !int_oe;
   endproperty
   a_mask: assert property (p_mask)
      else $error("masked source drove pin");
endmodule

// ---- logic/itp_pkg.sv ----
// Shared constants and types for the I2C target with interrupt pulse
package itp_pkg;
   // Bus address and the byte register space seen from the I2C side
   localparam logic [6:0] TARGET_ADDR   = 7'h74;
   localparam int         USER_REGS     = 8;
   localparam logic [7:0] STATUS_IDX    = 8'h08;
   localparam logic [7:0] MASK_IDX      = 8'h09;
   localparam logic [7:0] LAST_IDX      = 8'h09;
   localparam logic [7:0] USER_RESET    = 8'h00;
   localparam logic [7:0] MASK_RESET    = 8'h00;
   localparam logic [7:0] UNMAPPED_BYTE = 8'h00;

   // Status byte layout, shared by status view, mask and edge tables
   typedef struct packed {
      logic rsv7;
      logic adapter_present;
      logic load_insert_two;
      logic load_insert_one;
      logic bus_rail_short_flag;
      logic over_temp;
      logic charge_done;
      logic rsv0;
   } itp_stat_t;

   localparam logic [7:0] EDGE_BOTH = 8'h46;
   localparam logic [7:0] RISE_ONLY = 8'h30;
   localparam logic [7:0] LEVEL_SRC = 8'h08;
   localparam logic [7:0] LATCH_SRC = 8'h30;

   // Interrupt pulse width
   localparam int PULSE_MS      = 1;
   localparam int CLK_PERIOD_PS = 4000;
   localparam int PULSE_CYCLES  = PULSE_MS * 1000000000 / CLK_PERIOD_PS;

   // APB register offsets and reset values
   localparam logic [7:0]  A_CTRL       = 8'h00;
   localparam logic [7:0]  A_IRQ_STAT   = 8'h04;
   localparam logic [7:0]  A_IRQ_MASK   = 8'h08;
   localparam logic [7:0]  A_LIVE       = 8'h0C;
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;
   localparam logic [2:0]  IRQ_M_RESET  = 3'h0;
   localparam int          IRQ_WRITE    = 0;
   localparam int          IRQ_NACK     = 1;
   localparam int          IRQ_STOP     = 2;

   typedef enum logic [3:0] {
      S_IDLE, S_ADDR, S_AACK, S_REG, S_PACK, S_WDATA, S_DACK,
      S_RDATA, S_MACK
   } itp_state_t;
endpackage

// ---- tb/itp_host_model.sv ----
// I2C bus master model standing in for the host controller
module itp_host_model #(
   parameter int Q = 10
) (
   // Clock
   input  wire logic clk,
   // Resolved bus lines
   input  wire logic scl,
   input  wire logic sda,
   // Pull-low drives, open drain
   output logic      scl_dn,
   output logic      sda_dn
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      scl_dn = 1'b0;
      sda_dn = 1'b0;
   end

   task automatic tk(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic start();
      sda_dn <= 1'b0;
      tk(Q);
      scl_dn <= 1'b0;
      tk(Q);
      sda_dn <= 1'b1;
      tk(Q);
      scl_dn <= 1'b1;
      tk(Q);
   endtask

   task automatic stop();
      sda_dn <= 1'b1;
      tk(Q);
      scl_dn <= 1'b0;
      tk(Q);
      sda_dn <= 1'b0;
      tk(Q);
   endtask

   // data set while SCL low, target may stretch
   task automatic bit_io(input logic b, output logic r, output logic st);
      sda_dn <= ~b;
      tk(Q);
      scl_dn <= 1'b0;
      tk(1);
      while (scl !== 1'b1) tk(1);
      tk(Q - 1);
      r = sda;
      tk(Q);
      st = (sda === r);
      scl_dn <= 1'b1;
      tk(Q);
   endtask

   // MSB first, ninth clock with SDA released
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r, st;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r, st);
      end
      bit_io(1'b1, r, st);
      ack = (r === 1'b0) && st;
   endtask

   // high ack on the last byte ends the read
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r, st;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r, st);
         d[i] = r;
      end
      bit_io(last, r, st);
   endtask
endmodule

// ---- tb/itp_target_tb_top.sv ----
// Self-checking bench: I2C transfers, interrupt pin and APB registers
module itp_target_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import itp_pkg::*;
   localparam int P = 50;
   typedef struct packed {
      logic [7:0] r;
      logic [7:0] d;
      logic [7:0] e;
   } itp_row_t;
   logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        scl_o, scl_oe, sda_o, sda_oe, int_o, int_oe;
   logic        scl_dn, sda_dn, ers, a1, a2, a4;
   logic [7:0]  wb[4], rb[4];
   logic        a3[4];
   itp_stat_t   status_i;
   int          n_errors = 0;
   int          n_checks = 0;
   wire logic   scl = ~(scl_oe | scl_dn);
   wire logic   sda = ~(sda_oe | sda_dn);
   itp_row_t    rows[5] = '{'{8'h00, 8'hA5, 8'hA5}, '{8'h04, 8'h5A, 8'h5A},
      '{8'h07, 8'hC3, 8'hC3}, '{STATUS_IDX, 8'hFF, 8'h00},
      '{MASK_IDX, 8'h00, 8'h00}};

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   itp_target #(.PULSE_CYCLES(P)) itp_target_inst (.clk(clk),
      .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .scl_i(scl), .scl_o(scl_o),
      .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .status_i(status_i), .int_o(int_o), .int_oe(int_oe));

   itp_host_model itp_host_model_inst (.clk(clk), .scl(scl), .sda(sda),
      .scl_dn(scl_dn), .sda_dn(sda_dn));

   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      chk("pready", 1, 32'(pready));
      rd = prdata;
      ers = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic iw(input logic [6:0] ad, input logic [7:0] r, input int n);
      a2 = 1'b0;
      a3 = '{default: 1'b0};
      itp_host_model_inst.start();
      itp_host_model_inst.wbyte({ad, 1'b0}, a1);
      if (a1) itp_host_model_inst.wbyte(r, a2);
      for (int i = 0; i < n && a1 && a2; i++) begin
         itp_host_model_inst.wbyte(wb[i], a3[i]);
         if (!a3[i]) break;
      end
      itp_host_model_inst.stop();
   endtask

   task automatic ir(input logic [7:0] r, input int n);
      itp_host_model_inst.start();
      itp_host_model_inst.wbyte({TARGET_ADDR, 1'b0}, a1);
      itp_host_model_inst.wbyte(r, a2);
      itp_host_model_inst.start();
      itp_host_model_inst.wbyte({TARGET_ADDR, 1'b1}, a4);
      chk("rd_acks", 1, 32'(a1 & a2 & a4));
      for (int i = 0; i < n; i++) begin
         itp_host_model_inst.rbyte(i == n - 1, rb[i]);
      end
      itp_host_model_inst.stop();
   endtask

   task automatic ev(input logic [7:0] v);
      @(posedge clk);
      status_i <= itp_stat_t'(v);
   endtask

   // Length of the next int_oe pulse, zero if none starts soon
   task automatic pulse(input string nm, input logic exp);
      int w, len;
      w = 0;
      len = 0;
      while (int_oe !== 1'b1 && w < 10) begin
         @(posedge clk);
         w++;
      end
      while (int_oe === 1'b1 && len < 4 * P) begin
         @(posedge clk);
         len++;
      end
      chk(nm, 32'(exp), 32'((len >= P - 1) && (len <= P + 2)));
   endtask

   initial begin
      repeat (80000) @(posedge clk);
      n_errors++;
      final_report();
   end

   initial begin
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      status_i = '0;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      apb(1'b0, A_CTRL, 32'h0);
      chk("ctrl", CTRL_RESET, rd);
      apb(1'b0, A_IRQ_MASK, 32'h0);
      chk("irq_mask", 32'(IRQ_M_RESET), rd);
      chk("int_oe", 0, 32'(int_oe));
      for (int k = 0; k < 5; k++) begin
         wb[0] = rows[k].d;
         iw(TARGET_ADDR, rows[k].r, 1);
         chk("w_ack", 1, 32'(a3[0]));
         ir(rows[k].r, 1);
         chk("r_data", 32'(rows[k].e), 32'(rb[0]));
      end
      apb(1'b1, A_IRQ_MASK, 32'h7);
      repeat (2) @(posedge clk);
      chk("irq_on", 1, 32'(irq));
      apb(1'b0, A_IRQ_STAT, 32'h0);
      chk("stat_wr", 1, 32'(rd[IRQ_WRITE]));
      apb(1'b1, A_IRQ_STAT, 32'h7);
      repeat (2) @(posedge clk);
      chk("irq_off", 0, 32'(irq));
      apb(1'b0, 8'h10, 32'h0);
      chk("pslverr", 1, 32'(ers));
      wb = '{8'h11, 8'h22, 8'h33, 8'h44};
      iw(TARGET_ADDR, 8'h01, 4);
      ir(8'h01, 4);
      for (int k = 0; k < 4; k++) begin
         chk("multi", 32'(wb[k]), 32'(rb[k]));
      end
      wb[0] = 8'h00;
      wb[1] = 8'hAA;
      iw(TARGET_ADDR, MASK_IDX, 2);
      chk("past_end", 0, 32'(a3[1]));
      ir(MASK_IDX, 2);
      chk("past_rd", 32'(UNMAPPED_BYTE), 32'(rb[1]));
      iw(7'h75, 8'h01, 1);
      chk("other_addr", 0, 32'(a1));
      iw(TARGET_ADDR, 8'h0A, 1);
      chk("bad_reg", 0, 32'(a2));
      apb(1'b0, A_IRQ_STAT, 32'h0);
      chk("stat_nack", 1, 32'(rd[IRQ_NACK]));
      ir(8'h01, 1);
      chk("idle_again", 32'h11, 32'(rb[0]));
      ev(8'h40);
      pulse("ac_rise", 1'b1);
      ev(8'h00);
      pulse("ac_fall", 1'b1);
      ev(8'h10);
      pulse("li_rise", 1'b1);
      ev(8'h00);
      pulse("li_fall", 1'b0);
      ev(8'h04);
      pulse("ot_rise", 1'b1);
      ir(STATUS_IDX, 1);
      chk("latched", 32'h14, 32'(rb[0]));
      ir(STATUS_IDX, 1);
      chk("cleared", 32'h04, 32'(rb[0]));
      ev(8'h0C);
      repeat (3 * P) @(posedge clk);
      chk("short_hold", 1, 32'(int_oe));
      chk("int_level", 0, 32'(int_o));
      ev(8'h04);
      repeat (8) @(posedge clk);
      chk("short_off", 0, 32'(int_oe));
      wb[0] = 8'h0A;
      iw(TARGET_ADDR, MASK_IDX, 1);
      ev(8'h06);
      pulse("masked", 1'b0);
      ev(8'h0E);
      repeat (10) @(posedge clk);
      chk("mask_short", 0, 32'(int_oe));
      ir(STATUS_IDX, 1);
      chk("masked_stat", 32'h0E, 32'(rb[0]));
      apb(1'b0, A_LIVE, 32'h0);
      chk("live", 32'h0000_0009, rd);
      apb(1'b1, A_CTRL, 32'h0);
      iw(TARGET_ADDR, 8'h01, 1);
      chk("disabled", 0, 32'(a1));
      apb(1'b1, A_CTRL, 32'h1);
      ir(8'h01, 1);
      chk("enabled", 32'h11, 32'(rb[0]));
      final_report();
   end
endmodule
